// ==== fsws_core_model.sv ====
// Core model: offers one instruction slot every other cycle.
// Assumes the sequencer's clock and reset; no slot runs while stalled.
`timescale 1ns/1ns
module fsws_core_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic stall_in,
  output logic instr_slot_out
);
  // Two no-ops follow every start, so slots keep running after it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || stall_in) begin
      instr_slot_out <= 1'b0;
    end else begin
      instr_slot_out <= !instr_slot_out;
    end
  end
endmodule

// ==== fsws_pkg.sv ====
// Constants shared by the flash self-write sequencer: register map, control fields,
// unlock keys, latch geometry and the timed-operation length.
// Assumes a 10 MHz instruction clock and a 32-bit AXI4-Lite register port.
package fsws_pkg;
  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFF_PROG_CTRL = 8'h00;
  localparam logic [7:0] OFF_UNLOCK_KEY = 8'h04;
  localparam logic [7:0] OFF_ADDR_LOW = 8'h08;
  localparam logic [7:0] OFF_ADDR_HIGH = 8'h0c;
  localparam logic [7:0] OFF_WORD_LOW = 8'h10;
  localparam logic [7:0] OFF_WORD_HIGH = 8'h14;

  // ************************************************************
  // Control register fields
  // ************************************************************
  localparam int BIT_FIXED_ONE = 7;
  localparam int BIT_CFG_SEL = 6;
  localparam int BIT_LATCH_ONLY = 5;
  localparam int BIT_ROW_ERASE = 4;
  localparam int BIT_PROG_ERR = 3;
  localparam int BIT_PROG_EN = 2;
  localparam int BIT_WR_START = 1;

  // ************************************************************
  // Unlock keys, latch geometry, blank value
  // ************************************************************
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam int LATCH_COUNT = 32;
  localparam int LATCH_IDX_W = 5;
  localparam int ROW_W = 10;
  localparam int ADDR_W = 15;
  localparam int WORD_W = 14;
  localparam logic [13:0] LATCH_BLANK = 14'h3fff;
  localparam logic [1:0] NOP_SLOTS = 2'h2;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_FREQ_KHZ = 10000;
  localparam int OP_TIME_US = 2000;
  localparam int OP_CYCLES = (OP_TIME_US * CLK_FREQ_KHZ) / 1000;

  // ************************************************************
  // Bus answers and state types
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {UL_IDLE, UL_GOT_FIRST, UL_ARMED} fsws_unlock_t;
  typedef enum logic [1:0] {SQ_IDLE, SQ_NOP, SQ_STALL} fsws_seq_t;
  typedef enum logic [1:0] {OP_NONE, OP_LOAD, OP_PROGRAM, OP_ERASE} fsws_op_t;
endpackage

// ==== fsws_sequencer.sv ====
// Flash self-write sequencer: AXI4-Lite registers, unlock detector, forced no-op slots,
// stall timer and the 32-word write latch bank.
// Assumes the core pulses instr_slot_in once per instruction slot on the same clock, and
// that por_n_in comes from the reset controller on the same clock.
//
// Behaviour
// - Unlock needs key 55h then AAh, then setting the write start bit.
// - Erase, latch load and programming only run after a completed unlock.
// - An interrupted unlock starts neither latch load nor programming.
// - Setting the write start bit forces the next two instruction slots to no-ops.
// - Erase or program stalls execution for about 2 ms, then resumes.
// - Clocks and peripherals keep running during the stall; it is not sleep.
// - Latch load only forces the two no-ops and does not stall.
// - After an erase, execution resumes at the third instruction after the start.
// - Erase works on whole rows picked by any address inside the row.
// - Programming does no erase; targets must already be blank.
// - One programming pass writes at most the 32 latches of a row.
// - Upper 10 address bits pick the row, lower 5 bits the latch.
// - Every programming or erase completion resets all latches to 3FFFh; a latch load does not.
// - With latch-only select set, unlocked write only loads the addressed latch.
// - With latch-only select clear, load the latch then program the whole row.
// - Write start bit is set by software only and cleared by hardware.
// - A reset during a write or erase sets the program error flag.
// - The unlock key register reads as all zeros.
// - Data pair holds a 14-bit word, address pair a 15-bit address.
`timescale 1ns/1ns
module fsws_sequencer #(
  parameter int OP_CYCLES = fsws_pkg::OP_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic por_n_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [7:0] s_axi_araddr_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  input wire logic instr_slot_in,
  output logic force_nop_out,
  output logic stall_out,
  output logic flash_erase_out,
  output logic flash_program_out,
  output logic flash_cfg_space_out,
  output logic [9:0] flash_row_out,
  output logic [447:0] flash_latch_data_out
);
  // ************************************************************
  // State
  // ************************************************************
  logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [7:0] aw_addr_reg, wdata_reg, rd_addr_reg;
  logic wstrb0_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic cfg_sel_reg, latch_only_reg, row_erase_reg, prog_err_reg, prog_en_reg, wr_start_reg;
  logic [14:0] prog_addr_reg;
  logic [13:0] prog_word_reg;
  logic [13:0] latch_reg [fsws_pkg::LATCH_COUNT];
  fsws_pkg::fsws_unlock_t unlock_reg;
  fsws_pkg::fsws_seq_t seq_reg;
  fsws_pkg::fsws_op_t op_reg;
  logic [1:0] nop_cnt_reg;
  logic [31:0] stall_cnt_reg;
  logic go_erase_reg, go_prog_reg, cfg_lat_reg;

  logic wr_fire, rd_fire, ctrl_wr, key_wr, start_try, start_ok, nop_done, stall_done;
  fsws_pkg::fsws_op_t op_next;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == fsws_pkg::OFF_PROG_CTRL) || (a == fsws_pkg::OFF_UNLOCK_KEY) ||
                (a == fsws_pkg::OFF_ADDR_LOW) || (a == fsws_pkg::OFF_ADDR_HIGH) ||
                (a == fsws_pkg::OFF_WORD_LOW) || (a == fsws_pkg::OFF_WORD_HIGH);
  endfunction

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  assign s_axi_awready_out = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready_out = !w_held_reg && !bvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr_in;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata_in[7:0];
      wstrb0_reg <= s_axi_wstrb_in[0];
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= fsws_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= is_mapped(aw_addr_reg) ? fsws_pkg::RESP_OKAY : fsws_pkg::RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  assign s_axi_arready_out = !rvalid_reg;
  assign rd_fire = s_axi_arvalid_in && !rvalid_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= fsws_pkg::RESP_OKAY;
      rd_addr_reg <= 8'h00;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rd_addr_reg <= s_axi_araddr_in;
      rresp_reg <= is_mapped(s_axi_araddr_in) ? fsws_pkg::RESP_OKAY : fsws_pkg::RESP_SLVERR;
      case (s_axi_araddr_in)
        fsws_pkg::OFF_PROG_CTRL: rdata_reg <= {24'h000000, 1'b1, cfg_sel_reg, latch_only_reg,
                                               row_erase_reg, prog_err_reg, prog_en_reg, wr_start_reg, 1'b0};
        fsws_pkg::OFF_ADDR_LOW: rdata_reg <= {24'h000000, prog_addr_reg[7:0]};
        fsws_pkg::OFF_ADDR_HIGH: rdata_reg <= {24'h000000, 1'b1, prog_addr_reg[14:8]};
        fsws_pkg::OFF_WORD_LOW: rdata_reg <= {24'h000000, prog_word_reg[7:0]};
        fsws_pkg::OFF_WORD_HIGH: rdata_reg <= {26'h0000000, prog_word_reg[13:8]};
        default: rdata_reg <= 32'h0000_0000; // Key register is write-only
      endcase
    end else if (s_axi_rready_in) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ************************************************************
  // Register writes
  // ************************************************************
  assign ctrl_wr = wr_fire && wstrb0_reg && (aw_addr_reg == fsws_pkg::OFF_PROG_CTRL);
  assign key_wr = wr_fire && wstrb0_reg && (aw_addr_reg == fsws_pkg::OFF_UNLOCK_KEY);
  assign start_try = ctrl_wr && wdata_reg[fsws_pkg::BIT_WR_START] && (seq_reg == fsws_pkg::SQ_IDLE);
  // Enable is taken from the byte being written, so a single write may enable and start
  assign start_ok = start_try && (unlock_reg == fsws_pkg::UL_ARMED) &&
                    wdata_reg[fsws_pkg::BIT_PROG_EN];

  always_comb begin
    if (wdata_reg[fsws_pkg::BIT_ROW_ERASE]) begin
      op_next = fsws_pkg::OP_ERASE;
    end else if (wdata_reg[fsws_pkg::BIT_LATCH_ONLY]) begin
      op_next = fsws_pkg::OP_LOAD;
    end else begin
      op_next = fsws_pkg::OP_PROGRAM;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cfg_sel_reg <= 1'b0;
      latch_only_reg <= 1'b0;
      row_erase_reg <= 1'b0;
      prog_en_reg <= 1'b0;
    end else if (ctrl_wr) begin
      cfg_sel_reg <= wdata_reg[fsws_pkg::BIT_CFG_SEL];
      latch_only_reg <= wdata_reg[fsws_pkg::BIT_LATCH_ONLY];
      row_erase_reg <= wdata_reg[fsws_pkg::BIT_ROW_ERASE];
      prog_en_reg <= wdata_reg[fsws_pkg::BIT_PROG_EN];
    end
  end

  // Software can only set it, and only a started operation does; hardware clears it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_start_reg <= 1'b0;
    end else if (start_ok) begin
      wr_start_reg <= 1'b1;
    end else if (nop_done && op_reg == fsws_pkg::OP_LOAD || stall_done) begin
      wr_start_reg <= 1'b0;
    end
  end

  // Power-on or software clears the error flag; a plain reset during an operation sets it
  always_ff @(posedge clk_in) begin
    if (!por_n_in) begin
      prog_err_reg <= 1'b0;
    end else if (!rst_n_in) begin
      prog_err_reg <= prog_err_reg || (seq_reg != fsws_pkg::SQ_IDLE && op_reg != fsws_pkg::OP_NONE);
    end else if (ctrl_wr && !wdata_reg[fsws_pkg::BIT_PROG_ERR]) begin
      prog_err_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prog_addr_reg <= 15'h0000;
      prog_word_reg <= 14'h0000;
    end else if (wr_fire && wstrb0_reg) begin
      case (aw_addr_reg)
        fsws_pkg::OFF_ADDR_LOW: prog_addr_reg[7:0] <= wdata_reg;
        fsws_pkg::OFF_ADDR_HIGH: prog_addr_reg[14:8] <= wdata_reg[6:0];
        fsws_pkg::OFF_WORD_LOW: prog_word_reg[7:0] <= wdata_reg;
        fsws_pkg::OFF_WORD_HIGH: prog_word_reg[13:8] <= wdata_reg[5:0];
        default: prog_addr_reg <= prog_addr_reg;
      endcase
    end
  end

  // ************************************************************
  // Unlock detector
  // ************************************************************
  // Any access other than the next expected step drops back to idle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      unlock_reg <= fsws_pkg::UL_IDLE;
    end else if (key_wr && wdata_reg == fsws_pkg::KEY_FIRST && unlock_reg == fsws_pkg::UL_IDLE) begin
      unlock_reg <= fsws_pkg::UL_GOT_FIRST;
    end else if (key_wr && wdata_reg == fsws_pkg::KEY_SECOND && unlock_reg == fsws_pkg::UL_GOT_FIRST) begin
      unlock_reg <= fsws_pkg::UL_ARMED;
    end else if (wr_fire || rd_fire) begin
      unlock_reg <= fsws_pkg::UL_IDLE;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  assign nop_done = (seq_reg == fsws_pkg::SQ_NOP) && instr_slot_in && (nop_cnt_reg == 2'h1);
  assign stall_done = (seq_reg == fsws_pkg::SQ_STALL) && (stall_cnt_reg == 32'h0000_0000);

  // Counting slots relies on the core turning them into no-ops while force_nop_out is high
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      seq_reg <= fsws_pkg::SQ_IDLE;
      op_reg <= fsws_pkg::OP_NONE;
      nop_cnt_reg <= 2'h0;
      stall_cnt_reg <= 32'h0000_0000;
    end else begin
      case (seq_reg)
        fsws_pkg::SQ_IDLE: begin
          if (start_try) begin
            seq_reg <= fsws_pkg::SQ_NOP;
            nop_cnt_reg <= fsws_pkg::NOP_SLOTS;
            op_reg <= start_ok ? op_next : fsws_pkg::OP_NONE;
          end
        end
        fsws_pkg::SQ_NOP: begin
          if (instr_slot_in) begin
            nop_cnt_reg <= nop_cnt_reg - 2'h1;
          end
          if (nop_done) begin
            if (op_reg == fsws_pkg::OP_ERASE || op_reg == fsws_pkg::OP_PROGRAM) begin
              seq_reg <= fsws_pkg::SQ_STALL;
              stall_cnt_reg <= 32'(OP_CYCLES - 1);
            end else begin
              seq_reg <= fsws_pkg::SQ_IDLE;
              op_reg <= fsws_pkg::OP_NONE;
            end
          end
        end
        fsws_pkg::SQ_STALL: begin
          stall_cnt_reg <= stall_cnt_reg - 32'h0000_0001;
          if (stall_done) begin
            seq_reg <= fsws_pkg::SQ_IDLE;
            op_reg <= fsws_pkg::OP_NONE;
          end
        end
        default: seq_reg <= fsws_pkg::SQ_IDLE;
      endcase
    end
  end

  // Only instruction issue is held; the clock is never gated
  assign force_nop_out = (seq_reg == fsws_pkg::SQ_NOP);
  assign stall_out = (seq_reg == fsws_pkg::SQ_STALL);

  // ************************************************************
  // Write latches and flash strobes
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < fsws_pkg::LATCH_COUNT; gi++) begin : g_latch
      always_ff @(posedge clk_in) begin
        if (!rst_n_in || stall_done) begin
          latch_reg[gi] <= fsws_pkg::LATCH_BLANK;
        end else if (nop_done && (op_reg == fsws_pkg::OP_LOAD || op_reg == fsws_pkg::OP_PROGRAM) &&
                     prog_addr_reg[4:0] == 5'(gi)) begin
          latch_reg[gi] <= prog_word_reg;
        end
      end
      assign flash_latch_data_out[gi*14 +: 14] = latch_reg[gi];
    end
  endgenerate

  // Program pulse never comes with erase; the array must already be blank
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      go_erase_reg <= 1'b0;
      go_prog_reg <= 1'b0;
      cfg_lat_reg <= 1'b0;
    end else begin
      go_erase_reg <= nop_done && op_reg == fsws_pkg::OP_ERASE;
      go_prog_reg <= nop_done && op_reg == fsws_pkg::OP_PROGRAM;
      if (nop_done) begin
        cfg_lat_reg <= cfg_sel_reg;
      end
    end
  end

  assign flash_erase_out = go_erase_reg;
  assign flash_program_out = go_prog_reg;
  assign flash_cfg_space_out = cfg_lat_reg;
  assign flash_row_out = prog_addr_reg[14:5];

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_lock_blocks_start: assert property (start_try && unlock_reg != fsws_pkg::UL_ARMED |=> op_reg == fsws_pkg::OP_NONE)
    else $error("operation started without unlock");
  a_nop_forced: assert property (start_try |=> force_nop_out && nop_cnt_reg == 2'h2)
    else $error("no-op slots not forced");
  a_stall_length: assert property ($rose(stall_out) |-> stall_cnt_reg == 32'(OP_CYCLES - 1))
    else $error("stall length wrong");
  a_stall_blank: assert property (stall_done |=> !stall_out && latch_reg[0] == fsws_pkg::LATCH_BLANK && !wr_start_reg)
    else $error("completion did not blank latches");
  a_load_nostall: assert property (nop_done && op_reg == fsws_pkg::OP_LOAD |=> !stall_out [*2])
    else $error("latch load stalled");
  a_wr_held: assert property (stall_out |-> wr_start_reg)
    else $error("start bit dropped during operation");
  a_key_zero: assert property (rvalid_reg && rd_addr_reg == fsws_pkg::OFF_UNLOCK_KEY |-> rdata_reg == 32'h0)
    else $error("key register read nonzero");
  a_enable_gate: assert property (start_try && !wdata_reg[fsws_pkg::BIT_PROG_EN] |=> op_reg == fsws_pkg::OP_NONE)
    else $error("start accepted without enable");
  a_erase_wins: assert property (start_ok && wdata_reg[fsws_pkg::BIT_ROW_ERASE] |=> op_reg == fsws_pkg::OP_ERASE)
    else $error("erase select not honoured");
  a_prog_pulse: assert property (nop_done && op_reg == fsws_pkg::OP_PROGRAM |=> flash_program_out && stall_out)
    else $error("program pulse missing");
  a_unlock_drop: assert property (rd_fire |=> unlock_reg == fsws_pkg::UL_IDLE)
    else $error("unlock survived another access");

  c_erase: cover property (go_erase_reg);
  c_program: cover property (go_prog_reg);
  c_load: cover property (nop_done && op_reg == fsws_pkg::OP_LOAD);
  c_locked_try: cover property (start_try && unlock_reg != fsws_pkg::UL_ARMED);
endmodule

// ==== tb_flash_self_write_sequencer.sv ====
// Bench for the flash self-write sequencer: AXI4-Lite master tasks, a core model
// for the slots, a latch reference and counters of stall cycles and pulses.
// Assumes a 10 MHz clock and a shortened timed operation.
`timescale 1ns/1ns
module tb_flash_self_write_sequencer;
  localparam int OP = 8;
  logic clk_in, rst_n_in, por_n_in, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic slot, fnop, stall, ers, prg, cfg, nop_d, snap_cfg;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat, d, seed;
  logic [1:0] bresp, rresp, r;
  logic [9:0] row;
  logic [447:0] lat, snap;
  logic [13:0] exp_l [32];
  logic [14:0] a;
  logic [13:0] w;
  int num_errors, checked, n_nop, n_stall, n_ers, n_prg, k, p0, s0, e0, n0;
  fsws_sequencer #(.OP_CYCLES(OP)) DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrdy), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(br), .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rresp), .instr_slot_in(slot), .force_nop_out(fnop), .stall_out(stall),
    .flash_erase_out(ers), .flash_program_out(prg), .flash_cfg_space_out(cfg), .flash_row_out(row),
    .flash_latch_data_out(lat));
  fsws_core_model core (.clk_in(clk_in), .rst_n_in(rst_n_in), .stall_in(stall), .instr_slot_out(slot));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = !clk_in;
  end
  // ****************************************
  // Monitors: counted with NBA so tasks read settled values
  // ****************************************
  always @(posedge clk_in) begin
    if (stall === 1'b1) n_stall <= n_stall + 1;
    if (ers === 1'b1) n_ers <= n_ers + 1;
    if (ers === 1'b1) snap_cfg <= cfg;
    if (prg === 1'b1) n_prg <= n_prg + 1;
    if (prg === 1'b1) snap <= lat;
    if (fnop === 1'b1 && nop_d !== 1'b1) n_nop <= n_nop + 1;
    nop_d <= fnop;
  end
  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic axw(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
    awa <= ad;
    wd <= dt;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
    rs = bresp;
    br <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic axr(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    ara <= ad;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arr) arv <= 1'b0;
    end while (!rv);
    dt = rdat;
    rs = rresp;
    rr <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wrc(input logic [7:0] ad, input logic [31:0] dt);
    axw(ad, dt, r);
    check(r, fsws_pkg::RESP_OKAY);
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
    axr(ad, d, r);
    check(d, e);
  endtask
  task automatic unlock();
    wrc(fsws_pkg::OFF_UNLOCK_KEY, 32'h55);
    wrc(fsws_pkg::OFF_UNLOCK_KEY, 32'haa);
  endtask
  task automatic set_aw();
    a = xs();
    w = xs();
    if (k == 0) a[4:0] = 5'h1f;
    wrc(fsws_pkg::OFF_ADDR_LOW, a[7:0]);
    wrc(fsws_pkg::OFF_ADDR_HIGH, a[14:8]);
    wrc(fsws_pkg::OFF_WORD_LOW, w[7:0]);
    wrc(fsws_pkg::OFF_WORD_HIGH, w[13:8]);
  endtask
  task automatic op(input logic [7:0] c);
    n0 = n_nop; s0 = n_stall; p0 = n_prg; e0 = n_ers;
    wrc(fsws_pkg::OFF_PROG_CTRL, c);
    repeat (2) @(posedge clk_in);
    while (fnop) @(posedge clk_in);
    repeat (2) @(posedge clk_in);
    while (stall) @(posedge clk_in);
    @(posedge clk_in);
    check(n_nop - n0, 1);
  endtask
  task automatic cmp_lat(input string t);
    for (int i = 0; i < 32; i++) check(lat[i * 14 +: 14], exp_l[i]);
    $display("test %s done", t);
  endtask
  initial begin
    seed = 32'h5712;
    {awv, wv, br, arv, rr, rst_n_in, por_n_in, awa, ara, wd} = '0;
    num_errors = 0; checked = 0; n_nop = 0; n_stall = 0; n_ers = 0; n_prg = 0; k = 0;
    for (int i = 0; i < 32; i++) exp_l[i] = fsws_pkg::LATCH_BLANK;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    por_n_in <= 1'b1;
    @(posedge clk_in);
    rdc(fsws_pkg::OFF_PROG_CTRL, 32'h80);
    rdc(fsws_pkg::OFF_UNLOCK_KEY, 32'h0);
    wrc(fsws_pkg::OFF_WORD_HIGH, 32'hff);
    rdc(fsws_pkg::OFF_WORD_HIGH, 32'h3f);
    wrc(fsws_pkg::OFF_ADDR_HIGH, 32'h7f);
    rdc(fsws_pkg::OFF_ADDR_HIGH, 32'hff);
    axw(8'h3c, 32'h1, r);
    check(r, fsws_pkg::RESP_SLVERR);
    axr(8'h3c, d, r);
    check(r, fsws_pkg::RESP_SLVERR);
    cmp_lat("reset");
    for (k = 0; k < 4; k++) begin
      set_aw();
      unlock();
      op(8'h26);
      check(n_stall - s0, 0);
      exp_l[a[4:0]] = w;
      cmp_lat("load");
    end
    for (k = 1; k < 4; k++) begin
      set_aw();
      if (k == 1) wrc(fsws_pkg::OFF_UNLOCK_KEY, 32'h55);
      if (k == 1) axr(fsws_pkg::OFF_ADDR_LOW, d, r);
      if (k == 1) wrc(fsws_pkg::OFF_UNLOCK_KEY, 32'haa);
      if (k == 2) wrc(fsws_pkg::OFF_UNLOCK_KEY, 32'haa);
      if (k == 2) wrc(fsws_pkg::OFF_UNLOCK_KEY, 32'h55);
      if (k == 3) unlock();
      op(k == 3 ? 8'h22 : 8'h26);
      cmp_lat("refused");
    end
    set_aw();
    unlock();
    op(8'h06);
    check(n_prg - p0, 1);
    check(n_stall - s0, OP);
    check(snap[a[4:0] * 14 +: 14], w);
    check(row, a[14:5]);
    for (int i = 0; i < 32; i++) exp_l[i] = fsws_pkg::LATCH_BLANK;
    rdc(fsws_pkg::OFF_PROG_CTRL, 32'h84);
    cmp_lat("program");
    set_aw();
    unlock();
    op(8'h26); // A loaded latch gives the erase something to blank
    unlock();
    op(8'h76);
    check(row, a[14:5]);
    check(n_ers - e0, 1);
    check(n_prg - p0, 0);
    check(n_stall - s0, OP);
    check(snap_cfg, 1'b1);
    cmp_lat("erase");
    set_aw();
    unlock();
    wrc(fsws_pkg::OFF_PROG_CTRL, 32'h06);
    while (!stall) @(posedge clk_in);
    rdc(fsws_pkg::OFF_ADDR_LOW, a[7:0]);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    rdc(fsws_pkg::OFF_PROG_CTRL, 32'h88);
    wrc(fsws_pkg::OFF_PROG_CTRL, 32'h0);
    rdc(fsws_pkg::OFF_PROG_CTRL, 32'h80);
    cmp_lat("abort");
    wrap_up();
  end
  initial begin
    repeat (8000) @(posedge clk_in);
    num_errors++;
    wrap_up();
  end
endmodule
